/* File: logic/sfc_pkg.sv */
package sfc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [9:0] IDX_SLOT_CFG   = 10'h011;
    localparam logic [9:0] IDX_EXT_SYNC   = 10'h038;
    localparam logic [9:0] IDX_CLK_CTRL   = 10'h04B;
    localparam logic [9:0] IDX_STATUS     = 10'h050;

    ////////////////////////////////////////////////////////////////////////
    // Slot configuration field positions
    localparam int SLOT_A_EN_BIT   = 0;
    localparam int SLOT_A_FMT_LSB  = 2;
    localparam int SLOT_B_EN_BIT   = 5;
    localparam int SLOT_B_FMT_LSB  = 6;
    localparam int FMT_W           = 3;

    // Sample clock control field positions
    localparam int OSC_BYP_BIT     = 8;
    localparam int CLK_RSV_LSB     = 9;
    localparam int CLK_RSV_W       = 7;
    localparam logic [6:0] CLK_RSV_RESET = 7'h13;

    // Status register bit positions
    localparam int ST_B_ALLOWED    = 0;
    localparam int ST_A_RSVD       = 1;
    localparam int ST_B_RSVD       = 2;
    localparam int ST_A_STORE      = 3;
    localparam int ST_B_STORE      = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [2:0]  FMT_RESET      = 3'h0;
    localparam logic [15:0] EXT_SYNC_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // FIFO data formats
    localparam logic [2:0] FMT_NONE   = 3'h0;
    localparam logic [2:0] FMT_SUM16  = 3'h1;
    localparam logic [2:0] FMT_SUM32  = 3'h2;
    localparam logic [2:0] FMT_CH16   = 3'h4;
    localparam logic [2:0] FMT_CH32   = 3'h6;

    // FIFO words of 16 bits per sample for each format
    localparam logic [3:0] WORDS_NONE  = 4'h0;
    localparam logic [3:0] WORDS_SUM16 = 4'h1;
    localparam logic [3:0] WORDS_SUM32 = 4'h2;
    localparam logic [3:0] WORDS_CH16  = 4'h4;
    localparam logic [3:0] WORDS_CH32  = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // Read data phase states
    typedef enum logic [1:0] {
        SFC_RD_IDLE = 2'b01,
        SFC_RD_WAIT = 2'b10
    } sfc_rd_state_t;

endpackage : sfc_pkg

/* File: logic/sfc_fmt_decode.sv */
`timescale 1ns/1ns
// Decodes one slot's FIFO format code into store control
module sfc_fmt_decode (
    // Format code
    input  wire logic [2:0] fmt_code,
    // Decoded format
    output logic            stores_data,
    output logic            per_channel,
    output logic            wide_32,
    output logic            reserved_code,
    output logic [3:0]      word_count
);

    // Reserved codes store nothing
    always_comb
    begin
        stores_data   = 1'b1;
        per_channel   = 1'b0;
        wide_32       = 1'b0;
        reserved_code = 1'b0;
        word_count    = sfc_pkg::WORDS_NONE;
        case (fmt_code)
            sfc_pkg::FMT_NONE:
            begin
                stores_data = 1'b0;
            end
            sfc_pkg::FMT_SUM16:
            begin
                word_count = sfc_pkg::WORDS_SUM16;
            end
            sfc_pkg::FMT_SUM32:
            begin
                wide_32    = 1'b1;
                word_count = sfc_pkg::WORDS_SUM32;
            end
            sfc_pkg::FMT_CH16:
            begin
                per_channel = 1'b1;
                word_count  = sfc_pkg::WORDS_CH16;
            end
            sfc_pkg::FMT_CH32:
            begin
                per_channel = 1'b1;
                wide_32     = 1'b1;
                word_count  = sfc_pkg::WORDS_CH32;
            end
            default:
            begin
                stores_data   = 1'b0;
                reserved_code = 1'b1;
            end
        endcase
    end

endmodule : sfc_fmt_decode

/* File: logic/sfc_slot_config.sv */
`timescale 1ns/1ns
// What this block does
// - Slot B code 6 stores four 32-bit extended samples; others reserved.
// - Slot B code 0 none, 1/2 sum of 16/32 bits, 4 four 16-bit.
// - Slot B stored only with equal averaging, or slot A format none.
// - Bit 5 of slot configuration enables slot B, reset zero.
// - Slot A code 0 none, code 1 16-bit sum, code 2 32-bit sum.
// - Slot A code 4 four 16-bit, code 6 four 32-bit; others reserved.
// - Bit 0 of slot configuration enables slot A, reset zero.
// - Bit 8 of sample clock control bypasses oscillator, reset zero.
module sfc_slot_config #(
    parameter int AVG_W = 3
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Averaging factors of both slots
    input  wire logic [AVG_W-1:0] first_slot_average,
    input  wire logic [AVG_W-1:0] second_slot_average,
    // Slot configuration
    output logic                  first_slot_enable,
    output logic                  second_slot_enable,
    output logic [2:0]            first_slot_fifo_format,
    output logic [2:0]            second_slot_fifo_format,
    output logic [15:0]           external_sync_startup_word,
    output logic                  sample_oscillator_bypass,
    // FIFO store control
    output logic                  first_slot_fifo_store,
    output logic                  second_slot_fifo_store,
    output logic [3:0]            first_slot_fifo_words,
    output logic [3:0]            second_slot_fifo_words,
    output logic                  first_slot_wide_32,
    output logic                  second_slot_wide_32,
    output logic                  first_slot_per_channel,
    output logic                  second_slot_per_channel
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic                      a_en_q;
    logic                      b_en_q;
    logic [2:0]                a_fmt_q;
    logic [2:0]                b_fmt_q;
    logic [15:0]               sync_q;
    logic                      byp_q;
    logic [6:0]                clk_rsv_q;

    // Bus pipeline
    logic                      wr_pend_q;
    logic                      rd_pend_q;
    logic [9:0]                idx_q;
    logic [31:0]               hrdata_q;
    sfc_pkg::sfc_rd_state_t    rd_state_q;

    // Decoded formats
    logic                      a_stores;
    logic                      b_stores;
    logic                      a_rsvd;
    logic                      b_rsvd;
    logic                      a_wide;
    logic                      b_wide;
    logic                      a_chan;
    logic                      b_chan;
    logic [3:0]                a_words;
    logic [3:0]                b_words;
    logic                      b_allowed;
    logic                      a_store_q;
    logic                      b_store_q;
    logic [3:0]                a_words_q;
    logic [3:0]                b_words_q;
    logic                      a_wide_q;
    logic                      b_wide_q;
    logic                      a_chan_q;
    logic                      b_chan_q;

    logic                      addr_phase;
    logic [31:0]               rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Address phase qualifier, whole-word transfers only
    assign addr_phase = hsel && hready && (htrans == sfc_pkg::HTRANS_NONSEQ)
                        && (hsize == sfc_pkg::HSIZE_WORD);

    // Capture address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q     <= 10'h000;
        end
        else if (hready)
        begin
            wr_pend_q <= addr_phase && hwrite;
            rd_pend_q <= addr_phase && !hwrite;
            idx_q     <= haddr[11:2];
        end
    end

    // Read phase: one wait state so a preceding write is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_state_q <= sfc_pkg::SFC_RD_IDLE;
            hrdata_q   <= 32'h0000_0000;
        end
        else
        begin
            case (rd_state_q)
                sfc_pkg::SFC_RD_IDLE:
                begin
                    if (rd_pend_q)
                    begin
                        rd_state_q <= sfc_pkg::SFC_RD_WAIT;
                        hrdata_q   <= rd_word;
                    end
                end
                sfc_pkg::SFC_RD_WAIT:
                begin
                    rd_state_q <= sfc_pkg::SFC_RD_IDLE;
                end
                default:
                begin
                    rd_state_q <= sfc_pkg::SFC_RD_IDLE;
                end
            endcase
        end
    end

    // Stall only the first cycle of a read data phase
    assign hreadyout = !(rd_pend_q && (rd_state_q == sfc_pkg::SFC_RD_IDLE));
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Read mux, unmapped and unused bits read zero; clock control reserved bits read back their stored value
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (idx_q == sfc_pkg::IDX_SLOT_CFG)
        begin
            rd_word[sfc_pkg::SLOT_A_EN_BIT] = a_en_q;
            rd_word[sfc_pkg::SLOT_B_EN_BIT] = b_en_q;
            rd_word[sfc_pkg::SLOT_A_FMT_LSB +: sfc_pkg::FMT_W] = a_fmt_q;
            rd_word[sfc_pkg::SLOT_B_FMT_LSB +: sfc_pkg::FMT_W] = b_fmt_q;
        end
        else if (idx_q == sfc_pkg::IDX_EXT_SYNC)
        begin
            rd_word[15:0] = sync_q;
        end
        else if (idx_q == sfc_pkg::IDX_CLK_CTRL)
        begin
            rd_word[sfc_pkg::OSC_BYP_BIT] = byp_q;
            rd_word[sfc_pkg::CLK_RSV_LSB +: sfc_pkg::CLK_RSV_W] = clk_rsv_q;
        end
        else if (idx_q == sfc_pkg::IDX_STATUS)
        begin
            rd_word[sfc_pkg::ST_B_ALLOWED] = b_allowed;
            rd_word[sfc_pkg::ST_A_RSVD]    = a_rsvd;
            rd_word[sfc_pkg::ST_B_RSVD]    = b_rsvd;
            rd_word[sfc_pkg::ST_A_STORE]   = a_store_q;
            rd_word[sfc_pkg::ST_B_STORE]   = b_store_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot configuration register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_en_q  <= 1'b0;
            b_en_q  <= 1'b0;
            a_fmt_q <= sfc_pkg::FMT_RESET;
            b_fmt_q <= sfc_pkg::FMT_RESET;
        end
        else if (wr_pend_q && (idx_q == sfc_pkg::IDX_SLOT_CFG))
        begin
            a_en_q  <= hwdata[sfc_pkg::SLOT_A_EN_BIT];
            b_en_q  <= hwdata[sfc_pkg::SLOT_B_EN_BIT];
            a_fmt_q <= hwdata[sfc_pkg::SLOT_A_FMT_LSB +: sfc_pkg::FMT_W];
            b_fmt_q <= hwdata[sfc_pkg::SLOT_B_FMT_LSB +: sfc_pkg::FMT_W];
        end
    end

    // External-sync startup word, value is software's duty
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_q <= sfc_pkg::EXT_SYNC_RESET;
        end
        else if (wr_pend_q && (idx_q == sfc_pkg::IDX_EXT_SYNC))
        begin
            sync_q <= hwdata[15:0];
        end
    end

    // Sample clock control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            byp_q     <= 1'b0;
            clk_rsv_q <= sfc_pkg::CLK_RSV_RESET;
        end
        else if (wr_pend_q && (idx_q == sfc_pkg::IDX_CLK_CTRL))
        begin
            byp_q     <= hwdata[sfc_pkg::OSC_BYP_BIT];
            clk_rsv_q <= hwdata[sfc_pkg::CLK_RSV_LSB +: sfc_pkg::CLK_RSV_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Format decoders for both slots
    sfc_fmt_decode u_dec_a (
        .fmt_code      (a_fmt_q),
        .stores_data   (a_stores),
        .per_channel   (a_chan),
        .wide_32       (a_wide),
        .reserved_code (a_rsvd),
        .word_count    (a_words)
    );

    sfc_fmt_decode u_dec_b (
        .fmt_code      (b_fmt_q),
        .stores_data   (b_stores),
        .per_channel   (b_chan),
        .wide_32       (b_wide),
        .reserved_code (b_rsvd),
        .word_count    (b_words)
    );

    // Slot B admission: same averaging or slot A format none
    assign b_allowed = (first_slot_average == second_slot_average)
                       || (a_fmt_q == sfc_pkg::FMT_NONE);

    // Registered FIFO store control
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            a_store_q <= 1'b0;
            b_store_q <= 1'b0;
            a_words_q <= sfc_pkg::WORDS_NONE;
            b_words_q <= sfc_pkg::WORDS_NONE;
            a_wide_q  <= 1'b0;
            b_wide_q  <= 1'b0;
            a_chan_q  <= 1'b0;
            b_chan_q  <= 1'b0;
        end
        else
        begin
            a_store_q <= a_en_q && a_stores;
            b_store_q <= b_en_q && b_stores && b_allowed;
            a_words_q <= (a_en_q && a_stores) ? a_words : sfc_pkg::WORDS_NONE;
            b_words_q <= (b_en_q && b_stores && b_allowed) ?
                         b_words : sfc_pkg::WORDS_NONE;
            a_wide_q  <= a_wide;
            b_wide_q  <= b_wide;
            a_chan_q  <= a_chan;
            b_chan_q  <= b_chan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign first_slot_enable          = a_en_q;
    assign second_slot_enable         = b_en_q;
    assign first_slot_fifo_format     = a_fmt_q;
    assign second_slot_fifo_format    = b_fmt_q;
    assign external_sync_startup_word = sync_q;
    assign sample_oscillator_bypass   = byp_q;
    assign first_slot_fifo_store      = a_store_q;
    assign second_slot_fifo_store     = b_store_q;
    assign first_slot_fifo_words      = a_words_q;
    assign second_slot_fifo_words     = b_words_q;
    assign first_slot_wide_32         = a_wide_q;
    assign second_slot_wide_32        = b_wide_q;
    assign first_slot_per_channel     = a_chan_q;
    assign second_slot_per_channel    = b_chan_q;

endmodule : sfc_slot_config

/* File: sim/sfc_slot_config_asserts.sv */
`timescale 1ns/1ns
// Port-level properties of the slot configuration block
module sfc_slot_config_asserts #(
    parameter int AVG_W = 3
) (
    // Clock and reset
    input wire logic             hclk,
    input wire logic             hresetn,
    // AHB-Lite slave
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [2:0]       hsize,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             hresp,
    // Averaging factors
    input wire logic [AVG_W-1:0] first_slot_average,
    input wire logic [AVG_W-1:0] second_slot_average,
    // Configuration and store control
    input wire logic             first_slot_enable,
    input wire logic             second_slot_enable,
    input wire logic [2:0]       first_slot_fifo_format,
    input wire logic [2:0]       second_slot_fifo_format,
    input wire logic [15:0]      external_sync_startup_word,
    input wire logic             sample_oscillator_bypass,
    input wire logic             first_slot_fifo_store,
    input wire logic             second_slot_fifo_store,
    input wire logic [3:0]       first_slot_fifo_words,
    input wire logic [3:0]       second_slot_fifo_words
);
    logic       wr_slot_q;
    logic       wr_sync_q;
    logic       wr_clk_q;
    logic       rd_q;
    logic       taken;
    logic [9:0] idx;
    logic       b_ok;

    // Accepted transfer and slot B admission
    assign taken = hsel && hready && htrans == sfc_pkg::HTRANS_NONSEQ
                   && hsize == sfc_pkg::HSIZE_WORD;
    assign idx   = haddr[11:2];
    assign b_ok  = second_slot_enable && (first_slot_fifo_format == 3'h0
                   || first_slot_average == second_slot_average);

    // Words per sample for a storing format code
    function automatic logic [3:0] words_of(input logic [2:0] c);
        words_of = (c == 3'h6) ? 4'h8 : (c == 3'h1 || c == 3'h2
                   || c == 3'h4) ? {1'b0, c} : 4'h0;
    endfunction : words_of

    // Marks the data phase of accepted writes to the three writable registers and of every accepted read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_slot_q <= 1'b0;
            wr_sync_q <= 1'b0;
            wr_clk_q  <= 1'b0;
            rd_q      <= 1'b0;
        end
        else
        begin
            wr_slot_q <= taken && hwrite && idx == sfc_pkg::IDX_SLOT_CFG;
            wr_sync_q <= taken && hwrite && idx == sfc_pkg::IDX_EXT_SYNC;
            wr_clk_q  <= taken && hwrite && idx == sfc_pkg::IDX_CLK_CTRL;
            rd_q      <= taken && !hwrite;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot B enable follows writes and holds otherwise; slot fields and bypass follow writes; sync word holds without a write
    property p_b_enable;
        @(posedge hclk) disable iff (!hresetn)
        second_slot_enable == ($past(wr_slot_q) ? $past(hwdata[5])
                               : $past(second_slot_enable));
    endproperty
    a_b_enable: assert property (p_b_enable)
        else $error("slot B enable does not follow its write");
    property p_a_fields;
        @(posedge hclk) disable iff (!hresetn)
        $past(wr_slot_q) |-> {second_slot_fifo_format, first_slot_fifo_format,
            first_slot_enable} == {$past(hwdata[8:6]), $past(hwdata[4:2]),
            $past(hwdata[0])};
    endproperty
    a_a_fields: assert property (p_a_fields)
        else $error("slot fields do not follow their write");
    property p_bypass;
        @(posedge hclk) disable iff (!hresetn)
        wr_clk_q |=> sample_oscillator_bypass == $past(hwdata[8]);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("oscillator bypass does not follow its write");
    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        !wr_sync_q |=> $stable(external_sync_startup_word);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync startup word changed without a write");

    ////////////////////////////////////////////////////////////////////////
    // Store control lags the configuration by one clock
    property p_a_store;
        @(posedge hclk) disable iff (!hresetn)
        first_slot_fifo_store == ($past(first_slot_enable)
            && $past(words_of(first_slot_fifo_format)) != 4'h0);
    endproperty
    a_a_store: assert property (p_a_store)
        else $error("slot A store flag wrong");
    property p_a_words;
        @(posedge hclk) disable iff (!hresetn)
        first_slot_fifo_words == ($past(first_slot_enable)
            ? $past(words_of(first_slot_fifo_format)) : 4'h0);
    endproperty
    a_a_words: assert property (p_a_words)
        else $error("slot A word count wrong");
    property p_b_store;
        @(posedge hclk) disable iff (!hresetn)
        second_slot_fifo_store == ($past(b_ok)
            && $past(words_of(second_slot_fifo_format)) != 4'h0);
    endproperty
    a_b_store: assert property (p_b_store)
        else $error("slot B store flag wrong");
    property p_b_words;
        @(posedge hclk) disable iff (!hresetn)
        second_slot_fifo_words == ($past(b_ok)
            ? $past(words_of(second_slot_fifo_format)) : 4'h0);
    endproperty
    a_b_words: assert property (p_b_words)
        else $error("slot B word count wrong");

    // Reads take one wait state and end with an OKAY response
    property p_rd_wait;
        @(posedge hclk) disable iff (!hresetn)
        rd_q |-> !hreadyout ##1 hreadyout && !hresp;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
endmodule : sfc_slot_config_asserts

bind sfc_slot_config sfc_slot_config_asserts #(.AVG_W(AVG_W)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .first_slot_average(first_slot_average),
    .second_slot_average(second_slot_average),
    .first_slot_enable(first_slot_enable),
    .second_slot_enable(second_slot_enable),
    .first_slot_fifo_format(first_slot_fifo_format),
    .second_slot_fifo_format(second_slot_fifo_format),
    .external_sync_startup_word(external_sync_startup_word),
    .sample_oscillator_bypass(sample_oscillator_bypass),
    .first_slot_fifo_store(first_slot_fifo_store),
    .second_slot_fifo_store(second_slot_fifo_store),
    .first_slot_fifo_words(first_slot_fifo_words),
    .second_slot_fifo_words(second_slot_fifo_words));

/* File: sim/slot_fifo_format_config_tb_top.sv */
`timescale 1ns/1ns
// Register-level bench for the slot configuration block
module slot_fifo_format_config_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  avg_a = 3'h1;
    logic [2:0]  avg_b = 3'h2;
    logic        en_a, en_b, byp, st_a, st_b, wd_a, wd_b, ch_a, ch_b;
    logic [2:0]  fmt_a, fmt_b;
    logic [15:0] sync_w;
    logic [3:0]  wc_a, wc_b;
    logic [31:0] rd, exp_w;
    logic [31:0] out_a, out_b;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    sfc_slot_config uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .first_slot_average(avg_a),
        .second_slot_average(avg_b), .first_slot_enable(en_a),
        .second_slot_enable(en_b), .first_slot_fifo_format(fmt_a),
        .second_slot_fifo_format(fmt_b),
        .external_sync_startup_word(sync_w),
        .sample_oscillator_bypass(byp), .first_slot_fifo_store(st_a),
        .second_slot_fifo_store(st_b), .first_slot_fifo_words(wc_a),
        .second_slot_fifo_words(wc_b), .first_slot_wide_32(wd_a),
        .second_slot_wide_32(wd_b), .first_slot_per_channel(ch_a),
        .second_slot_per_channel(ch_b));

    // Store control of each slot as {wide, per-channel, store, words}
    assign out_a = {25'h0, wd_a, ch_a, st_a, wc_a};
    assign out_b = {25'h0, wd_b, ch_b, st_b, wc_b};

    // 10 MHz clock and cycle ceiling
    always #50 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            num_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One single AHB-Lite transfer, returns read data
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask : xfer

    // Expected {wide, per-channel, store, words} for a format code
    function automatic logic [31:0] exp_out(input logic [2:0] c,
                                            input logic on);
        logic ok;
        ok = on && (c == 3'h1 || c == 3'h2 || c == 3'h4 || c == 3'h6);
        exp_out = {25'h0, c == 3'h2 || c == 3'h6, c == 3'h4 || c == 3'h6,
                   ok, ok ? (c == 3'h6 ? 4'h8 : {1'b0, c}) : 4'h0};
    endfunction : exp_out

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 32'h0000_0044, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        xfer(1'b0, 32'h0000_012C, 32'h0, rd);
        chk(rd, 32'h0000_2600);
        chk({31'h0, en_a}, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            xfer(1'b1, 32'h0000_0044, 32'h0000_0001 | (c << 2), rd);
            xfer(1'b0, 32'h0000_0044, 32'h0, rd);
            chk(rd, 32'h0000_0001 | (c << 2));
            chk(out_a, exp_out(c[2:0], 1'b1));
            xfer(1'b1, 32'h0000_0044, 32'h0000_0020 | (c << 6), rd);
            repeat (2) @(posedge hclk);
            exp_w = exp_out(c[2:0], 1'b1);
            chk(out_b, exp_w);
            xfer(1'b0, 32'h0000_0140, 32'h0, rd);
            exp_w = {27'h0, exp_w[4], 1'b0, !exp_w[4] && c != 0, 2'h1};
            chk(rd, exp_w);
        end
        xfer(1'b1, 32'h0000_0044, 32'h0000_0100, rd);
        repeat (2) @(posedge hclk);
        chk(out_b, exp_out(3'h4, 1'b0));
        xfer(1'b1, 32'h0000_0044, 32'h0000_0124, rd);
        repeat (2) @(posedge hclk);
        chk(out_b, exp_out(3'h4, 1'b0));
        xfer(1'b0, 32'h0000_0140, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        avg_b <= 3'h1;
        repeat (2) @(posedge hclk);
        chk(out_b, exp_out(3'h4, 1'b1));
        xfer(1'b0, 32'h0000_0140, 32'h0, rd);
        chk(rd, 32'h0000_0011);
        xfer(1'b1, 32'h0000_00E0, 32'h0000_4000, rd);
        xfer(1'b0, 32'h0000_00E0, 32'h0, rd);
        chk(rd, 32'h0000_4000);
        chk({16'h0, sync_w}, 32'h0000_4000);
        xfer(1'b1, 32'h0000_012C, 32'h0000_2700, rd);
        xfer(1'b0, 32'h0000_012C, 32'h0, rd);
        chk(rd, 32'h0000_2700);
        chk({31'h0, byp}, 32'h1);
        // Reset in mid-run returns slot B enable, bypass, sync word and clock control to reset values
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({14'h0, en_b, byp, sync_w}, 32'h0);
        xfer(1'b0, 32'h0000_012C, 32'h0, rd);
        chk(rd, 32'h0000_2600);
        xfer(1'b1, 32'h0000_0000, 32'h0000_FFFF, rd);
        xfer(1'b0, 32'h0000_0000, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        final_report();
    end
endmodule : slot_fifo_format_config_tb_top
